/* hdl/exception_lowpower_control.sv */
// Purpose: interrupt latch, break handling, wait/stop sequencing
// Assumes: cpu signals instruction boundaries on mclk; flag access
//          blocking is applied by peripherals via clear_allow
// Notes: apb slave answers with pready in the access cycle
//
// The APB register port was chosen for this implementation.
`include "exc_lp_defs.svh"
module exception_lowpower_control
  import exc_lp_pkg::*;
#(
  parameter int NUM_IRQ        = 8,
  parameter int LONG_RECOVERY  = `RECOVERY_LONG_CYCLES,
  parameter int SHORT_RECOVERY = `RECOVERY_SHORT_CYCLES
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [15:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_IRQ-1:0] irq_req,
  input  wire logic [NUM_IRQ-1:0] irq_enable,
  input  wire logic               mask_bit,
  input  wire logic               insn_boundary,
  input  wire logic               swi_exec,
  input  wire logic               wait_exec,
  input  wire logic               stop_exec,
  input  wire logic               rti_done,
  input  wire logic               break_req,
  input  wire reset_src_t         reset_src,
  input  wire logic               short_recovery_select,
  input  wire logic               oscillator_in_stop_enable,
  input  wire logic               watchdog_disable,
  output logic                    int_start,
  output logic [7:0]              vector_sel,
  output logic                    stack_pc_minus_one,
  output logic                    set_mask,
  output logic                    clear_mask,
  output logic                    stack_high_index,
  output logic                    cpu_clk_en,
  output logic                    periph_clk_en,
  output logic                    osc_en,
  output logic                    counter_reset,
  output logic                    watchdog_run,
  output logic                    in_break,
  output logic                    clear_allow
);
  localparam logic [7:0] SWI_VECTOR = 8'hff;
  localparam int CW = $clog2(LONG_RECOVERY + 1);
  localparam logic [7:0] BFC_RST = `BFC_RESET;

  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 254)
      $error("NUM_IRQ out of range");
    if (SHORT_RECOVERY < 1 || SHORT_RECOVERY > LONG_RECOVERY)
      $error("recovery counts invalid");
  end

  lp_state_t        state_r, state_nxt;
  logic [CW-1:0]    count_r;
  logic             latched_r;
  logic [7:0]       latched_vec_r;
  logic             break_r;
  logic             bws_flag_r;
  logic             break_clear_enable_r;
  reset_src_t       rss_r;
  logic [31:0]      prdata_r;
  logic             int_start_r, pc1_r, setm_r, clrm_r;
  logic             in_reset_r;

  wire any_reset   = |reset_src;
  wire [NUM_IRQ-1:0] eligible = irq_req & irq_enable;
  wire any_elig    = |eligible;
  wire can_take    = any_elig && !mask_bit;

  // lowest index is highest priority
  logic [7:0] win_idx;
  always_comb begin
    win_idx = 8'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i])
        win_idx = 8'(i);
    end
  end

  wire apb_acc   = psel && penable;
  wire apb_wr    = apb_acc && pwrite;
  wire apb_rd    = apb_acc && !pwrite;
  wire hit_bws   = paddr == `ADDR_BREAK_WAKE_STATUS;
  wire hit_rss   = paddr == `ADDR_RESET_SOURCE_STATUS;
  wire hit_bfc   = paddr == `ADDR_BREAK_FLAG_CLEAR;
  wire hit_any   = hit_bws || hit_rss || hit_bfc;

  wire [7:0] bws_rd = 8'(bws_flag_r) << `BWS_FLAG_BIT;
  wire [7:0] bfc_rd = 8'(break_clear_enable_r) << `BFC_ENABLE_BIT;
  wire [7:0] rss_rd = {rss_r, 1'b0};
  wire [7:0] rd_byte = hit_bws ? bws_rd :
                       hit_rss ? rss_rd :
                       hit_bfc ? bfc_rd : 8'h00;

  wire boundary    = insn_boundary || rti_done;
  wire in_lowpower = state_r == ST_WAIT || state_r == ST_STOP;
  wire wake_irq    = can_take || break_req;
  wire take_now    = state_r == ST_RUN && boundary && !any_reset;

  // state machine for low-power modes
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_exec)
          state_nxt = ST_STOP;
        else if (wait_exec)
          state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (wake_irq)
          state_nxt = ST_STACK;
      end
      ST_STOP: begin
        if (wake_irq || any_reset)
          state_nxt = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (count_r == '0)
          state_nxt = in_reset_r ? ST_RUN : ST_STACK;
      end
      ST_STACK: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
    if (any_reset && state_r != ST_STOP && state_r != ST_RECOVER)
      state_nxt = ST_RUN;
  end

  always_ff @(posedge mclk) begin
    if (rst)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // recovery counter, loads on stop exit
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_r    <= '0;
      in_reset_r <= 1'b0;
    end else if (state_r == ST_STOP) begin
      count_r    <= '0;
      in_reset_r <= any_reset;
      if (any_reset || !short_recovery_select) begin
        count_r    <= CW'(LONG_RECOVERY - 1);
      end else if (wake_irq) begin
        count_r    <= CW'(SHORT_RECOVERY - 1);
      end
      if (!(wake_irq || any_reset))
        count_r <= '0;
    end else if (state_r == ST_RECOVER && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  // interrupt latch; once held, no other source displaces it
  always_ff @(posedge mclk) begin
    if (rst || any_reset) begin
      latched_r     <= 1'b0;
      latched_vec_r <= 8'h00;
    end else if (!latched_r && (can_take || break_req)) begin
      latched_r     <= 1'b1;
      latched_vec_r <= break_req ? SWI_VECTOR : win_idx;
    end else if (latched_r && (int_start_r || (!mask_bit && !any_elig
                 && !break_r))) begin
      latched_r     <= 1'b0;
    end
  end

  wire entry_hw  = latched_r && (take_now || state_r == ST_STACK)
                   && !int_start_r;
  wire entry_swi = take_now && swi_exec;

  always_ff @(posedge mclk) begin
    if (rst) begin
      int_start_r <= 1'b0;
      pc1_r       <= 1'b0;
      setm_r      <= 1'b0;
      clrm_r      <= 1'b0;
      vector_sel  <= 8'h00;
    end else begin
      int_start_r <= entry_hw || entry_swi;
      setm_r      <= entry_hw || entry_swi;
      pc1_r       <= entry_hw && !entry_swi && latched_vec_r != SWI_VECTOR;
      clrm_r      <= state_r == ST_RUN && (wait_exec || stop_exec);
      if (entry_swi)
        vector_sel <= SWI_VECTOR;
      else if (entry_hw)
        vector_sel <= latched_vec_r;
    end
  end

  // break tracking and wake flag
  always_ff @(posedge mclk) begin
    if (rst || any_reset) begin
      break_r    <= 1'b0;
      bws_flag_r <= 1'b0;
    end else begin
      if (break_req)
        break_r <= 1'b1;
      else if (rti_done)
        break_r <= 1'b0;
      if (apb_wr && hit_bws && !pwdata[`BWS_FLAG_BIT])
        bws_flag_r <= 1'b0;
      if (in_lowpower && break_req)
        bws_flag_r <= 1'b1;
    end
  end

  // control register
  always_ff @(posedge mclk) begin
    if (rst || any_reset)
      break_clear_enable_r <= BFC_RST[`BFC_ENABLE_BIT];
    else if (apb_wr && hit_bfc)
      break_clear_enable_r <= pwdata[`BFC_ENABLE_BIT];
  end

  // reset source record; read clears, a new reset wins
  always_ff @(posedge mclk) begin
    if (rst)
      rss_r <= '{power_on: 1'b1, default: 1'b0};
    else if (reset_src.power_on)
      rss_r <= '{power_on: 1'b1, default: 1'b0};
    else if (any_reset)
      rss_r <= reset_src;
    else if (apb_rd && hit_rss)
      rss_r <= '0;
  end

  always_ff @(posedge mclk) begin
    if (rst)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_r <= {24'h00_0000, rd_byte};
  end

  // clock and enable outputs, all registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_clk_en       <= 1'b1;
      periph_clk_en    <= 1'b1;
      osc_en           <= 1'b1;
      counter_reset    <= 1'b0;
      watchdog_run     <= 1'b1;
      in_break         <= 1'b0;
      clear_allow      <= 1'b1;
      stack_high_index <= 1'b0;
      pslverr          <= 1'b0;
      pready           <= 1'b0;
    end else begin
      cpu_clk_en    <= state_nxt == ST_RUN || state_nxt == ST_STACK;
      periph_clk_en <= state_nxt != ST_STOP && state_nxt != ST_RECOVER;
      osc_en        <= state_nxt != ST_STOP || oscillator_in_stop_enable;
      counter_reset <= state_nxt == ST_STOP;
      watchdog_run  <= !watchdog_disable && state_nxt != ST_STOP;
      in_break      <= break_r;
      // peripherals gate both clear steps on this level
      clear_allow   <= !break_r || break_clear_enable_r;
      stack_high_index <= 1'b0;
      pready        <= psel && !penable;
      pslverr       <= psel && !penable && !hit_any;
    end
  end

  assign prdata             = prdata_r;
  assign int_start          = int_start_r;
  assign stack_pc_minus_one = pc1_r;
  assign set_mask           = setm_r;
  assign clear_mask         = clrm_r;
endmodule : exception_lowpower_control

/* hdl/exc_lp_defs.svh */
// Purpose: constants for the exception and low-power control block
// Assumes: byte-wide registers on a 32-bit apb word, low bits used
// Notes: register map and recovery counts
//
// Behaviour
// - latch and arbitrate interrupt, hold until serviced; the latch drops if unmasked with no enabled request or break left
// - service only at boundary, unmasked and enabled
// - highest priority pending source wins
// - pending interrupt serviced right after return
// - stack on entry, set mask; high index excluded
// - software interrupt ignores mask, stacks current pc
// - any reset overrides all interrupts; a reset in the ST_STACK cycle still starts entry
// - break request forces software interrupt vector
// - in break, flag clears blocked unless enabled
// - flag cleared in break stays cleared
// - two-step clears protected across break entry
// - wait/stop clear mask, stop cpu clock
// - wait stops cpu clock only; stack next cycle
// - watchdog runs in wait unless disabled
// - stop resets counter, gates clocks, maybe oscillator
// - interrupt exit from stop: 4096 or 32 cycles
// - reset exit from stop: always 4096 cycles
// - counter held in stop, times recovery
// - break wake flag set on break exit, write-0 clear
// - reset source register clears on read; power-on
// - record source of last reset
// - registers at fe00, fe01, fe03
`ifndef EXC_LP_DEFS_SVH
`define EXC_LP_DEFS_SVH
`define ADDR_BREAK_WAKE_STATUS   16'hfe00
`define ADDR_RESET_SOURCE_STATUS 16'hfe01
`define ADDR_BREAK_FLAG_CLEAR    16'hfe03
`define BWS_FLAG_BIT             1
`define BFC_ENABLE_BIT           7
`define RSS_POWER_ON_BIT         7
`define RSS_PIN_BIT              6
`define RSS_WATCHDOG_BIT         5
`define RSS_BAD_OPCODE_BIT       4
`define RSS_BAD_FETCH_BIT        3
`define RSS_MONITOR_BIT          2
`define RSS_LOW_VOLTAGE_BIT      1
`define RECOVERY_LONG_CYCLES     4096
`define RECOVERY_SHORT_CYCLES    32
`define BFC_RESET                8'h00
`endif

/* hdl/exc_lp_pkg.sv */
// Purpose: types for the exception and low-power control block
// Assumes: nothing beyond the defs header
// Notes: reset sources travel as one struct
package exc_lp_pkg;
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch;
    logic monitor;
    logic low_voltage;
  } reset_src_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER, ST_STACK
  } lp_state_t;
endpackage : exc_lp_pkg

/* verification/exc_lp_assertions.sv */
// Purpose: port-level checks of exception and low-power control
// Assumes: single mclk domain, rst synchronous active high
// Notes: bound into every instance of the block
module exc_lp_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       wait_exec,
  input wire logic       stop_exec,
  input wire logic       oscillator_in_stop_enable,
  input wire logic       watchdog_disable,
  input wire logic       clear_mask,
  input wire logic       set_mask,
  input wire logic       int_start,
  input wire logic [7:0] vector_sel,
  input wire logic       stack_pc_minus_one,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_en,
  input wire logic       counter_reset,
  input wire logic       watchdog_run
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_CLEAR_MASK: assert property (
    wait_exec || stop_exec |=> clear_mask)
    else $error("mask not cleared by low-power entry");
  AST_WAIT_CLOCKS: assert property (
    wait_exec |=> !cpu_clk_en && periph_clk_en)
    else $error("wrong clocks in wait");
  AST_STOP_GATE: assert property (
    stop_exec |=> counter_reset && !periph_clk_en)
    else $error("stop did not gate clocks");
  AST_STOP_OSC: assert property (
    stop_exec && !oscillator_in_stop_enable |=> !osc_en)
    else $error("oscillator left on in stop");
  AST_WATCHDOG: assert property (
    !cpu_clk_en && periph_clk_en && !watchdog_disable |-> watchdog_run)
    else $error("watchdog halted in wait");
  AST_ENTRY_MASK: assert property (int_start |-> set_mask)
    else $error("entry without mask set");
  AST_PC_KIND: assert property (
    int_start |-> (vector_sel == 8'hff) == !stack_pc_minus_one)
    else $error("wrong stacked pc kind");
  AST_STOP_HOLD: assert property (counter_reset |-> !int_start)
    else $error("stacking while counter held");
  AST_RECOVER_OFF: assert property (
    $fell(counter_reset) |-> (!cpu_clk_en) [*8])
    else $error("clocks back before recovery");
endmodule : exc_lp_checker

bind exception_lowpower_control exc_lp_checker exc_lp_checker_inst (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .wait_exec(wait_exec), .stop_exec(stop_exec),
  .oscillator_in_stop_enable(oscillator_in_stop_enable),
  .watchdog_disable(watchdog_disable), .clear_mask(clear_mask),
  .set_mask(set_mask), .int_start(int_start), .vector_sel(vector_sel),
  .stack_pc_minus_one(stack_pc_minus_one), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .osc_en(osc_en),
  .counter_reset(counter_reset), .watchdog_run(watchdog_run)
);

/* verification/cpu_core_model.sv */
// Purpose: cpu core stand-in giving boundaries and instructions
// Assumes: one instruction per four running clocks
// Notes: cmd 1 soft interrupt, 2 wait, 3 stop, at next boundary
module cpu_core_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       cpu_clk_en,
  input  wire logic       set_mask,
  input  wire logic       clear_mask,
  input  wire logic       cli,
  input  wire logic [1:0] cmd,
  output logic            insn_boundary,
  output logic            soft_int_exec,
  output logic            wait_exec,
  output logic            stop_exec,
  output logic            mask_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  // no boundaries while the core is unclocked
  wire        bnd_w = cpu_clk_en && cnt_r == 2'h3;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r         <= 2'h0;
      insn_boundary <= 1'b0;
      soft_int_exec <= 1'b0;
      wait_exec     <= 1'b0;
      stop_exec     <= 1'b0;
      mask_bit      <= 1'b1;
    end else begin
      if (cpu_clk_en) cnt_r <= cnt_r + 2'h1;
      insn_boundary <= bnd_w;
      soft_int_exec <= bnd_w && cmd == 2'h1;
      wait_exec     <= bnd_w && cmd == 2'h2;
      stop_exec     <= bnd_w && cmd == 2'h3;
      if (set_mask) mask_bit <= 1'b1;
      else if (clear_mask || cli) mask_bit <= 1'b0;
    end
  end
endmodule : cpu_core_model

/* verification/exception_lowpower_control_test.sv */
// Purpose: self-checking bench for exception and low-power control
// Assumes: apb answers without wait states, core model drives cpu
// Notes: long recovery shortened to 64 cycles
module exception_lowpower_control_test import exc_lp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG = 64;
  localparam int SHORT = 32;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cli = 0;
  logic break_req = 0, short_sel = 0, pready, pslverr, errv;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv;
  logic [7:0] irq_req = '0, vector_sel;
  logic [1:0] cmd = '0;
  reset_src_t src = '0;
  logic bnd, soft_int_exec, wait_exec, stop_exec, mask_bit, int_start;
  logic pcm1, set_mask, clear_mask, cpu_clk_en, periph_clk_en, osc_en;
  logic counter_reset, watchdog_run, in_break, clear_allow, shi;
  int num_errors = 0, checks_done = 0, cyc = 0, nwait;

  exception_lowpower_control #(.LONG_RECOVERY(LONG))
    exception_lowpower_control_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
    .irq_enable(8'hfd), .mask_bit(mask_bit), .insn_boundary(bnd),
    .swi_exec(soft_int_exec), .wait_exec(wait_exec),
    .stop_exec(stop_exec), .rti_done(1'b0), .break_req(break_req),
    .reset_src(src), .short_recovery_select(short_sel),
    .oscillator_in_stop_enable(1'b0), .watchdog_disable(1'b0),
    .int_start(int_start), .vector_sel(vector_sel),
    .stack_pc_minus_one(pcm1), .set_mask(set_mask),
    .clear_mask(clear_mask), .stack_high_index(shi),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_en(osc_en), .counter_reset(counter_reset),
    .watchdog_run(watchdog_run), .in_break(in_break),
    .clear_allow(clear_allow));
  cpu_core_model cpu_core_model_inst (
    .mclk(mclk), .rst(rst), .cpu_clk_en(cpu_clk_en),
    .set_mask(set_mask), .clear_mask(clear_mask), .cli(cli),
    .cmd(cmd), .insn_boundary(bnd), .soft_int_exec(soft_int_exec),
    .wait_exec(wait_exec), .stop_exec(stop_exec), .mask_bit(mask_bit));

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps a following call from driving psel twice
    @(posedge mclk);
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", exp, rdv);
  endtask : rd

  task automatic issue(input logic [1:0] c);
    cmd <= c;
    nwait = 0;
    while ((soft_int_exec | wait_exec | stop_exec) !== 1'b1
           && nwait < 99) begin
      @(posedge mclk);
      nwait++;
    end
    cmd <= 2'h0;
  endtask : issue

  task automatic wait_int();
    nwait = 0;
    while (int_start !== 1'b1 && nwait < 9000) begin
      @(posedge mclk);
      nwait++;
    end
  endtask : wait_int

  task automatic t_regs();
    rd(16'hfe01, 32'h0000_0080);
    rd(16'hfe01, 32'h0000_0000);
    rd(16'hfe03, 32'h0000_0000);
    rd(16'hfe00, 32'h0000_0000);
    rd(16'hfe02, 32'h0000_0000);
    chk("pslverr", 1'b1, errv);
  endtask : t_regs

  task automatic t_irq();
    cli <= 1'b1;
    @(posedge mclk);
    cli <= 1'b0;
    irq_req <= 8'h26;
    wait_int();
    chk("vector_sel", 8'h02, vector_sel);
    chk("pc_minus_one", 1'b1, pcm1);
    chk("stack_high_index", 1'b0, shi);
    irq_req <= 8'h00;
    issue(2'h1);
    wait_int();
    chk("soft vector", 8'hff, vector_sel);
    chk("soft pc", 1'b0, pcm1);
  endtask : t_irq

  task automatic stop_wake(input logic short, input logic by_reset);
    int lo;
    lo = (short && !by_reset) ? SHORT : LONG;
    short_sel <= short;
    issue(2'h3);
    repeat (2) @(posedge mclk);
    chk("counter_reset", 1'b1, counter_reset);
    chk("osc_en", 1'b0, osc_en);
    if (by_reset) src.pin <= 1'b1;
    else irq_req[3] <= 1'b1;
    @(posedge mclk);
    src <= '0;
    nwait = 1;
    while (cpu_clk_en !== 1'b1 && nwait < 9000) begin
      @(posedge mclk);
      nwait++;
    end
    chk("recovery", 1'b1, nwait >= lo && nwait <= lo + 8);
    if (by_reset) rd(16'hfe01, 32'h0000_0040);
    else begin
      wait_int();
      chk("wake vector", 8'h03, vector_sel);
    end
    irq_req <= 8'h00;
  endtask : stop_wake

  task automatic t_break();
    issue(2'h2);
    @(posedge mclk);
    chk("watchdog_run", 1'b1, watchdog_run);
    break_req <= 1'b1;
    wait_int();
    break_req <= 1'b0;
    chk("break vector", 8'hff, vector_sel);
    chk("clear_allow", 1'b0, clear_allow);
    apb(1'b1, 16'hfe03, 32'h0000_0080);
    @(posedge mclk);
    chk("clear_allow", 1'b1, clear_allow);
    rd(16'hfe00, 32'h0000_0002);
    apb(1'b1, 16'hfe00, 32'h0000_0000);
    rd(16'hfe00, 32'h0000_0000);
    src.monitor <= 1'b1;
    @(posedge mclk);
    src <= '0;
    repeat (2) @(posedge mclk);
    chk("in_break", 1'b0, in_break);
    rd(16'hfe01, 32'h0000_0004);
  endtask : t_break

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_irq();
    stop_wake(1'b1, 1'b0);
    stop_wake(1'b0, 1'b1);
    t_break();
    summarize();
  end
endmodule : exception_lowpower_control_test
